/* File: hdl/hrp_pkg.sv */
// hrp_pkg: constants and types shared by both ends of the host register port.
// assumes both ends run on one 125 MHz core clock and meet through hrp_link_if.
// How it works
// [R1] data bus undriven while chip select high
// [R2] serial mode: data pin 6 selects clock phase
// [R3] host keeps clock phase low by default
// [R4] swap input: 0 LSB first, 1 MSB first
// [R5] swap never moves read or burst flag
// [R6] host drives serial clock on data pin 2
// [R7] host sends command and data on pin 1
// [R8] device returns read data on pin 0
// [R9] strobes count only while chip select low
// [R10] separate strobes: drive data while read low
// [R11] data strobe: drive while strobe low, level high
// [R12] separate strobes: write at write strobe rise
// [R13] data strobe: write at strobe rise, level low
// [R14] unmasked interrupt pulls interrupt line low
// [R15] line released once all sources serviced
// [R16] masks: global, framer, line unit, error tester
// [R17] mode strap: 0 parallel, 1 serial, pulled low
// [R18] status pin driven only when mode bit set
// [R19] timing select: 1 data strobe, low in serial
// [R20] thirteen bit address, bit 12 most significant
// [R21] serial mode: data pin 7 selects polarity
// [R22] serial mode ignores strobes, other pins undriven
// [R23] serial frame: control word then data byte
package hrp_pkg;
    localparam int CLK_MHZ = 125;
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam int CTRL_BITS = 16;
    localparam int SPI_BITS = CTRL_BITS + DATA_W;
    // serial control word, in order on the wire
    localparam logic [3:0] RW_POS = 4'h0;
    localparam logic [3:0] BURST_POS = 4'h1;
    localparam logic [3:0] ADDR_LAST = 4'(2 + ADDR_W - 1);
    localparam logic [3:0] CTRL_LAST = 4'(CTRL_BITS - 1);
    localparam logic [2:0] DATA_LAST = 3'h7;
    localparam logic [2:0] PREFETCH_BIT = 3'h4;
    // shared data pins in serial mode
    localparam int PIN_MISO = 0;
    localparam int PIN_MOSI = 1;
    localparam int PIN_SCLK = 2;
    localparam int PIN_SWAP = 5;
    localparam int PIN_PHASE = 6;
    localparam int PIN_POLARITY = 7;
    localparam logic [7:0] SPI_DEV_OE = 8'h01;
    localparam logic [7:0] SPI_HOST_OE = 8'hE6;
    localparam logic SPI_SEL_DEFAULT = 1'b0;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;
    // host timing
    localparam int SETUP_NS = 24;
    localparam int STROBE_NS = 128;
    localparam int HOLD_NS = 24;
    localparam int SCLK_HALF_NS = 80;
    localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int HOLD_CYC = (HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0] SETUP_END = 8'(SETUP_CYC - 1);
    localparam logic [7:0] STROBE_END = 8'(STROBE_CYC - 1);
    localparam logic [7:0] HOLD_END = 8'(HOLD_CYC - 1);
    localparam logic [7:0] HALF_END = 8'(SCLK_HALF_CYC - 1);
    localparam logic [5:0] HALF_LAST = 6'(2 * SPI_BITS);
    // host command registers
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_ADDR = 4'h1;
    localparam logic [3:0] REG_WDATA = 4'h2;
    localparam logic [3:0] REG_CMD = 4'h3;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_RDATA = 4'h5;
    localparam int CTRL_W = 6;
    localparam int CTRL_SPI = 0;
    localparam int CTRL_BTS = 1;
    localparam int CTRL_CPOL = 2;
    localparam int CTRL_CPHA = 3;
    localparam int CTRL_SWAP = 4;
    localparam int CTRL_BURST = 5;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;

    typedef enum logic [1:0] {STS_ANALOG_LOSS, STS_SIG_FREEZE, STS_FRAMER_LOSS} hrp_status_sel_t;
    typedef enum logic [2:0] {HS_IDLE, HS_SETUP, HS_STROBE, HS_HOLD, HS_SPI} hrp_host_state_t;
endpackage

/* File: hdl/hrp_link_if.sv */
// hrp_link_if: pins between host and device, with drive resolution.
// assumes an undriven data pin reads low and the interrupt line is pulled high.
`timescale 1ns/10ps
`default_nettype none
interface hrp_link_if;
    import hrp_pkg::*;
    logic chipSelectN;
    logic readStrobeN;
    logic writeStrobeN;
    logic busTimingSelect;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] devDataOut;
    logic [DATA_W-1:0] devDataOe;
    logic [DATA_W-1:0] hostDataOut;
    logic [DATA_W-1:0] hostDataOe;
    logic [DATA_W-1:0] dataBus;
    logic interruptOutN;
    logic interruptOe;
    logic interruptLine;
    logic statusOut;
    logic statusOe;
    logic spiSelectHost;
    logic statusLine;

    assign dataBus = (devDataOe & devDataOut) | (~devDataOe & hostDataOe & hostDataOut);
    assign interruptLine = interruptOe ? interruptOutN : 1'b1;
    assign statusLine = statusOe ? statusOut : spiSelectHost;

    modport device (
        input chipSelectN, readStrobeN, writeStrobeN, busTimingSelect, addr, dataBus, statusLine,
        output devDataOut, devDataOe, interruptOutN, interruptOe, statusOut, statusOe
    );
    modport host (
        input dataBus, interruptLine,
        output chipSelectN, readStrobeN, writeStrobeN, busTimingSelect, addr, hostDataOut, hostDataOe,
        output spiSelectHost
    );
endinterface
`default_nettype wire

/* File: hdl/hrp_device_end.sv */
// hrp_device_end: device side of the host register port, parallel or serial.
// assumes all link pins are asynchronous to core_clk; register map sits on the user side.
`timescale 1ns/10ps
`default_nettype none
module hrp_device_end
    import hrp_pkg::*;
#(
    parameter int NUM_FRAMERS = 8,
    parameter int NUM_LIUS = 8,
    parameter int NUM_BERTS = 8
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // link pins
    hrp_link_if.device link,
    // register map access
    output logic [ADDR_W-1:0] regAddr,
    output logic [DATA_W-1:0] regWrData,
    output logic regWr,
    output logic regRd,
    input wire logic [DATA_W-1:0] regRdData,
    // interrupt sources and masks
    input wire logic globalIrqEnable,
    input wire logic [NUM_FRAMERS-1:0] framerIrq,
    input wire logic [NUM_FRAMERS-1:0] framerIrqEn,
    input wire logic [NUM_LIUS-1:0] liuIrq,
    input wire logic [NUM_LIUS-1:0] liuIrqEn,
    input wire logic [NUM_BERTS-1:0] bertIrq,
    input wire logic [NUM_BERTS-1:0] bertIrqEn,
    // status pin function
    input wire logic statusPinMode,
    input wire logic [1:0] statusSelect,
    input wire logic lossAnalog,
    input wire logic sigFreeze,
    input wire logic lossFramer,
    // strap result
    output logic spiMode
);
    typedef struct packed {
        logic [1:0] strapS;
        logic [1:0] strapCnt;
        logic spiMode;
        logic [1:0] csS;
        logic [1:0] rdS;
        logic [1:0] wrS;
        logic [1:0] btsS;
        logic [1:0][ADDR_W-1:0] addrS;
        logic [1:0][DATA_W-1:0] dinS;
        logic csPrev;
        logic rdPrev;
        logic wrPrev;
        logic sclkPrev;
        logic [ADDR_W-1:0] addrPrev;
        logic [DATA_W-1:0] dinPrev;
        logic rdBusy;
        logic rdWait;
        logic spiFirst;
        logic [DATA_W-1:0] rdData;
        logic regWr;
        logic regRd;
        logic [ADDR_W-1:0] regAddr;
        logic [DATA_W-1:0] regWrData;
        logic [3:0] bitCnt;
        logic [2:0] dataCnt;
        logic [2:0] emitCnt;
        logic ctrlDone;
        logic isRead;
        logic burst;
        logic done;
        logic misoBit;
        logic [ADDR_W-1:0] spiAddr;
        logic [DATA_W-1:0] rxData;
        logic [DATA_W-1:0] txSr;
        logic irqOe;
        logic statusOe;
        logic statusOut;
    } hrp_dev_state_t;

    hrp_dev_state_t q;
    hrp_dev_state_t s;
    logic ready;
    logic readAct;
    logic spiSel;

    // sync stages hold strobes active high so an all-zero reset means idle
    assign ready = q.strapCnt == STRAP_SETTLE;
    assign readAct = ready && !q.spiMode && q.csS[1] && q.rdS[1] && (!q.btsS[1] || !q.wrS[1]); // [R9] [R10] [R11]
    assign spiSel = ready && q.spiMode && q.csS[1];

    always_comb
    begin
        logic writeEdge;
        logic sclk;
        logic cpol;
        logic cpha;
        logic swap;
        logic mosi;
        logic edgeSeen;
        logic leading;
        logic sampleEv;
        logic shiftEv;
        logic [ADDR_W-1:0] newAddr;
        logic [DATA_W-1:0] newData;
        s = q;
        s.strapS = {q.strapS[0], link.statusLine};
        s.csS = {q.csS[0], ~link.chipSelectN};
        s.rdS = {q.rdS[0], ~link.readStrobeN};
        s.wrS = {q.wrS[0], ~link.writeStrobeN};
        s.btsS = {q.btsS[0], link.busTimingSelect};
        s.addrS = {q.addrS[0], link.addr};
        s.dinS = {q.dinS[0], link.dataBus};
        s.csPrev = q.csS[1];
        s.rdPrev = q.rdS[1];
        s.wrPrev = q.wrS[1];
        s.addrPrev = q.addrS[1];
        s.dinPrev = q.dinS[1];
        s.sclkPrev = q.dinS[1][PIN_SCLK];
        s.regWr = 1'b0;
        s.regRd = 1'b0;
        s.rdWait = q.regRd;
        // strap is followed for a few cycles after release, then frozen
        if (q.strapCnt != STRAP_SETTLE)
        begin
            s.strapCnt = q.strapCnt + 2'h1;
            s.spiMode = q.strapS[1]; // [R17]
        end
        // parallel port
        writeEdge = ready && !q.spiMode && q.csPrev && (q.btsS[1] ?
            (q.rdPrev && !q.rdS[1] && q.wrPrev) : (q.wrPrev && !q.wrS[1])); // [R12] [R13] [R22]
        s.rdBusy = readAct;
        if (readAct && !q.rdBusy)
        begin
            s.regRd = 1'b1;
            s.regAddr = q.addrS[1]; // [R20]
        end
        if (writeEdge)
        begin
            s.regWr = 1'b1;
            s.regAddr = q.addrPrev;
            s.regWrData = q.dinPrev;
        end
        if (q.rdWait)
        begin
            s.rdData = regRdData;
            if (q.spiFirst)
            begin
                s.txSr = regRdData;
                s.spiFirst = 1'b0;
            end
        end
        // serial port
        sclk = q.dinS[1][PIN_SCLK];
        cpol = q.dinS[1][PIN_POLARITY]; // [R21]
        cpha = q.dinS[1][PIN_PHASE]; // [R2]
        swap = q.dinS[1][PIN_SWAP];
        mosi = q.dinS[1][PIN_MOSI];
        edgeSeen = sclk != q.sclkPrev;
        leading = edgeSeen && (q.sclkPrev == cpol);
        sampleEv = cpha ? (edgeSeen && !leading) : leading;
        shiftEv = edgeSeen && !sampleEv;
        newAddr = swap ? {q.spiAddr[ADDR_W-2:0], mosi} : {mosi, q.spiAddr[ADDR_W-1:1]}; // [R4]
        newData = swap ? {q.rxData[DATA_W-2:0], mosi} : {mosi, q.rxData[DATA_W-1:1]}; // [R4]
        if (!spiSel)
        begin
            s.bitCnt = 4'h0;
            s.dataCnt = 3'h0;
            s.emitCnt = 3'h0;
            s.ctrlDone = 1'b0;
            s.done = 1'b0;
            s.spiFirst = 1'b0;
        end
        else
        begin
            if (sampleEv && !q.done)
            begin
                if (!q.ctrlDone)
                begin
                    s.bitCnt = q.bitCnt + 4'h1;
                    // flag positions are fixed whatever the swap setting
                    if (q.bitCnt == RW_POS)
                        s.isRead = mosi; // [R5] [R23]
                    else if (q.bitCnt == BURST_POS)
                        s.burst = mosi; // [R5] [R23]
                    else if (q.bitCnt <= ADDR_LAST)
                        s.spiAddr = newAddr; // [R23]
                    // fetch early; the pad bit covers the register map latency
                    if (q.bitCnt == ADDR_LAST && q.isRead)
                    begin
                        s.regRd = 1'b1;
                        s.regAddr = newAddr;
                        s.spiFirst = 1'b1;
                    end
                    if (q.bitCnt == CTRL_LAST)
                        s.ctrlDone = 1'b1;
                end
                else
                begin
                    s.rxData = newData;
                    s.dataCnt = q.dataCnt + 3'h1;
                    // burst reads prefetch mid-byte so the next byte is ready at the wrap
                    if (q.isRead && q.burst && q.dataCnt == PREFETCH_BIT)
                    begin
                        s.regRd = 1'b1;
                        s.regAddr = q.spiAddr + 13'h1;
                        s.spiAddr = q.spiAddr + 13'h1;
                    end
                    if (q.dataCnt == DATA_LAST)
                    begin
                        if (!q.isRead)
                        begin
                            s.regWr = 1'b1; // [R23]
                            s.regAddr = q.spiAddr;
                            s.regWrData = newData;
                            if (q.burst)
                                s.spiAddr = q.spiAddr + 13'h1;
                        end
                        s.done = !q.burst;
                    end
                end
            end
            if (shiftEv && q.ctrlDone && q.isRead)
            begin
                s.misoBit = swap ? q.txSr[DATA_W-1] : q.txSr[0]; // [R4] [R8]
                s.emitCnt = q.emitCnt + 3'h1;
                if (q.emitCnt == DATA_LAST)
                    s.txSr = q.rdData;
                else
                    s.txSr = swap ? {q.txSr[DATA_W-2:0], 1'b0} : {1'b0, q.txSr[DATA_W-1:1]};
            end
        end
        // interrupt: sources hold their level until serviced
        s.irqOe = ready && globalIrqEnable && (|(framerIrq & framerIrqEn) || |(liuIrq & liuIrqEn)
            || |(bertIrq & bertIrqEn)); // [R14] [R15] [R16]
        s.statusOe = ready && statusPinMode; // [R18]
        unique case (hrp_status_sel_t'(statusSelect))
            STS_ANALOG_LOSS: s.statusOut = lossAnalog;
            STS_SIG_FREEZE: s.statusOut = sigFreeze;
            STS_FRAMER_LOSS: s.statusOut = lossFramer;
            default: s.statusOut = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            q <= '0;
        else
            q <= s;
    end

    // oe follows chip select after the sync delay
    assign link.devDataOe = spiSel ? SPI_DEV_OE : {DATA_W{readAct}}; // [R1] [R8] [R22]
    assign link.devDataOut = q.spiMode ? {{(DATA_W-1){1'b0}}, q.misoBit} : q.rdData; // [R10] [R11]
    assign link.interruptOutN = 1'b0;
    assign link.interruptOe = q.irqOe; // [R14] [R15]
    assign link.statusOut = q.statusOut;
    assign link.statusOe = q.statusOe; // [R18]
    assign regAddr = q.regAddr;
    assign regWrData = q.regWrData;
    assign regWr = q.regWr;
    assign regRd = q.regRd;
    assign spiMode = q.spiMode;
endmodule
`default_nettype wire

/* File: hdl/hrp_host_end.sv */
// hrp_host_end: host controller driving the register port in either mode.
// assumes the device was reset after any change of the serial/parallel strap.
`timescale 1ns/10ps
`default_nettype none
module hrp_host_end
    import hrp_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // link pins
    hrp_link_if.host link,
    // command port
    input wire logic [3:0] cmdAddr,
    input wire logic [15:0] cmdWrData,
    input wire logic cmdWr,
    input wire logic cmdRd,
    output logic [15:0] cmdRdData
);
    typedef struct packed {
        hrp_host_state_t st;
        logic [7:0] cnt;
        logic [5:0] half;
        logic [CTRL_W-1:0] ctrl;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rdata;
        logic isRead;
        logic done;
        logic [1:0][DATA_W-1:0] dS;
        logic [1:0] irqS;
        logic csAct;
        logic strobe;
        logic [DATA_W-1:0] dOut;
        logic [DATA_W-1:0] dOe;
        logic [15:0] rdOut;
    } hrp_host_state_s_t;

    hrp_host_state_s_t q;
    hrp_host_state_s_t s;

    function automatic logic txBit(input logic [4:0] idx, input logic rd, input logic burst,
        input logic swap, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        logic [4:0] k;
        k = idx - 5'h2;
        if (idx == 5'(RW_POS))
            txBit = rd;
        else if (idx == 5'(BURST_POS))
            txBit = burst;
        else if (idx <= 5'(ADDR_LAST))
            txBit = swap ? a[4'(ADDR_W - 1) - k[3:0]] : a[k[3:0]];
        else if (idx <= 5'(CTRL_LAST))
            txBit = 1'b0;
        else
            txBit = swap ? d[DATA_LAST - idx[2:0]] : d[idx[2:0]];
    endfunction

    always_comb
    begin
        logic cpol;
        logic cpha;
        logic swap;
        logic sclk;
        logic [5:0] mosiHalf;
        logic [DATA_W-1:0] pins;
        s = q;
        cpol = q.ctrl[CTRL_CPOL];
        cpha = q.ctrl[CTRL_CPHA];
        swap = q.ctrl[CTRL_SWAP];
        s.dS = {q.dS[0], link.dataBus};
        s.irqS = {q.irqS[0], ~link.interruptLine};
        s.rdOut = 16'h0000;
        if (cmdRd)
        begin
            unique case (cmdAddr)
                REG_CTRL: s.rdOut = {10'h000, q.ctrl};
                REG_ADDR: s.rdOut = {3'h0, q.addr};
                REG_WDATA: s.rdOut = {8'h00, q.wdata};
                REG_STATUS:
                begin
                    s.rdOut = {13'h0000, q.irqS[1], q.done, q.st != HS_IDLE};
                    s.done = 1'b0;
                end
                REG_RDATA: s.rdOut = {8'h00, q.rdata};
                default: s.rdOut = 16'h0000;
            endcase
        end
        if (cmdWr)
        begin
            unique case (cmdAddr)
                REG_CTRL: s.ctrl = cmdWrData[CTRL_W-1:0];
                REG_ADDR: s.addr = cmdWrData[ADDR_W-1:0];
                REG_WDATA: s.wdata = cmdWrData[DATA_W-1:0];
                REG_CMD:
                    if (q.st == HS_IDLE)
                    begin
                        s.isRead = cmdWrData[0];
                        s.st = q.ctrl[CTRL_SPI] ? HS_SPI : HS_SETUP;
                        s.half = 6'h00;
                    end
                default: ;
            endcase
        end
        s.cnt = q.cnt + 8'h01;
        unique case (q.st)
            HS_IDLE:
            begin
                s.csAct = 1'b0;
                s.strobe = 1'b0;
            end
            HS_SETUP:
            begin
                s.csAct = 1'b1; // [R9]
                if (q.cnt == SETUP_END)
                    s.st = HS_STROBE;
            end
            HS_STROBE:
            begin
                s.strobe = 1'b1;
                if (q.cnt == STROBE_END)
                begin
                    s.strobe = 1'b0;
                    if (q.isRead)
                        s.rdata = q.dS[1];
                    s.st = HS_HOLD;
                end
            end
            HS_HOLD:
                if (q.cnt == HOLD_END)
                begin
                    s.csAct = 1'b0;
                    s.done = 1'b1;
                    s.st = HS_IDLE;
                end
            HS_SPI:
            begin
                s.csAct = 1'b1;
                if (q.cnt == HALF_END)
                begin
                    s.cnt = 8'h00;
                    s.half = q.half + 6'h01;
                    // miso sampled at the device's own sample edge
                    if (q.half[0] == cpha && q.half < HALF_LAST && q.half[5:1] >= 5'(CTRL_BITS))
                        s.rdata[swap ? DATA_LAST - q.half[3:1] : q.half[3:1]] = q.dS[1][PIN_MISO]; // [R4]
                    if (q.half == HALF_LAST)
                    begin
                        s.csAct = 1'b0;
                        s.done = 1'b1;
                        s.st = HS_IDLE;
                    end
                end
            end
        endcase
        if (s.st != q.st)
            s.cnt = 8'h00;
        // pin images
        sclk = (q.st == HS_SPI && q.half < HALF_LAST && q.half[0]) ? ~cpol : cpol;
        mosiHalf = (cpha && q.half != 6'h00) ? q.half - 6'h01 : q.half;
        pins = 8'h00;
        pins[PIN_POLARITY] = cpol;
        pins[PIN_PHASE] = cpha; // [R3]
        pins[PIN_SWAP] = swap;
        pins[PIN_SCLK] = sclk; // [R6]
        pins[PIN_MOSI] = txBit(mosiHalf[5:1], q.isRead, q.ctrl[CTRL_BURST], swap, q.addr, q.wdata); // [R5] [R7]
        if (q.ctrl[CTRL_SPI])
        begin
            s.dOut = pins;
            s.dOe = SPI_HOST_OE;
        end
        else
        begin
            s.dOut = q.wdata;
            s.dOe = (s.csAct && !q.isRead) ? 8'hFF : 8'h00;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            q <= '0;
        else
            q <= s;
    end

    // strobes decoded per timing style; serial mode keeps them idle unless BTS is set, which pulls write strobe low for writes
    assign link.chipSelectN = ~q.csAct; // [R9]
    assign link.readStrobeN = q.ctrl[CTRL_BTS] ? ~q.strobe : ~(q.strobe && q.isRead);
    assign link.writeStrobeN = q.ctrl[CTRL_BTS] ? !(q.csAct && !q.isRead) : ~(q.strobe && !q.isRead);
    assign link.busTimingSelect = q.ctrl[CTRL_SPI] ? 1'b0 : q.ctrl[CTRL_BTS]; // [R19]
    assign link.addr = q.addr; // [R20]
    assign link.hostDataOut = q.dOut;
    assign link.hostDataOe = q.dOe;
    assign link.spiSelectHost = q.ctrl[CTRL_SPI]; // [R17]
    assign cmdRdData = q.rdOut;
endmodule
`default_nettype wire

/* File: test/hrp_link_sva.sv */
// hrp_link_sva: checks on the link pins between both ends.
// assumes resetn is the device end's reset, one core clock.
`timescale 1ns/10ps
`default_nettype none
module hrp_link_sva
    import hrp_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // link pins
    input wire logic chipSelectN,
    input wire logic readStrobeN,
    input wire logic writeStrobeN,
    input wire logic busTimingSelect,
    input wire logic spiSelectHost,
    input wire logic [DATA_W-1:0] devDataOe
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    wire logic rdLow = !spiSelectHost && !chipSelectN && !readStrobeN;
    a_idle_undriven: assert property (chipSelectN [*5] |-> devDataOe == 8'h00)
        else $error("bus driven while deselected");
    a_strobe_read: assert property ((rdLow && !busTimingSelect) [*8] |-> devDataOe == 8'hFF)
        else $error("strobe read not driven");
    a_dstrobe_read: assert property ((rdLow && busTimingSelect && writeStrobeN) [*8] |-> devDataOe == 8'hFF)
        else $error("data strobe read not driven");
    a_write_undriven: assert property ((!chipSelectN && !writeStrobeN) [*8] |-> devDataOe == 8'h00)
        else $error("bus driven during write");
    a_strobe_release: assert property ((!spiSelectHost && readStrobeN) [*6] |-> devDataOe == 8'h00)
        else $error("bus held after strobe");
    a_spi_pins_free: assert property (spiSelectHost |-> (devDataOe & 8'hFE) == 8'h00)
        else $error("serial mode drives data pins");
    a_spi_miso_drive: assert property ((spiSelectHost && !chipSelectN) [*5] |-> devDataOe[0])
        else $error("serial output not driven");
    a_strobe_needs_cs: assert property ($fell(readStrobeN) |-> !chipSelectN)
        else $error("strobe without chip select");
    c_par_read: cover property ((rdLow && !busTimingSelect) [*8]);
    c_ds_read: cover property ((rdLow && busTimingSelect) [*8]);
    c_spi_frame: cover property ((spiSelectHost && !chipSelectN) [*5]);
endmodule
`default_nettype wire

/* File: test/host_register_access_port_tb.sv */
// host_register_access_port_tb: both ends joined, driven through host commands.
// assumes the register map is a byte array kept here.
`timescale 1ns/10ps
`default_nettype none
module host_register_access_port_tb
    import hrp_pkg::*;
    ;
    logic core_clk, resetn = 1'b0, devRun = 1'b1;
    wire logic devRstN = resetn & devRun;
    logic [3:0] cmdAddr = 4'h0;
    logic [15:0] cmdWrData = 16'h0000, cmdRdData, rv;
    logic cmdWr = 1'b0, cmdRd = 1'b0, regWr, regRd, spiMode, statusPinMode = 1'b0, globalIrqEnable = 1'b0;
    logic [ADDR_W-1:0] regAddr;
    logic [7:0] regWrData, regRdData, mem [0:8191];
    logic [2:0][7:0] irq = 24'h000000, irqEn = 24'h000000;
    logic [1:0] statusSelect = 2'h0;
    logic [2:0] stat = 3'h5;
    int errTotal = 0, cmpCount = 0, k;
    hrp_link_if link ();
    hrp_device_end hrp_device_end_i (.core_clk, .resetn(devRstN), .link, .regAddr, .regWrData, .regWr, .regRd,
        .regRdData, .globalIrqEnable, .framerIrq(irq[0]), .framerIrqEn(irqEn[0]), .liuIrq(irq[1]),
        .liuIrqEn(irqEn[1]), .bertIrq(irq[2]), .bertIrqEn(irqEn[2]), .statusPinMode, .statusSelect,
        .lossAnalog(stat[0]), .sigFreeze(stat[1]), .lossFramer(stat[2]), .spiMode);
    hrp_host_end hrp_host_end_i (.core_clk, .resetn, .link, .cmdAddr, .cmdWrData, .cmdWr, .cmdRd, .cmdRdData);
    hrp_link_sva hrp_link_sva_i (.core_clk, .resetn(devRstN), .chipSelectN(link.chipSelectN),
        .readStrobeN(link.readStrobeN), .writeStrobeN(link.writeStrobeN), .busTimingSelect(link.busTimingSelect),
        .spiSelectHost(link.spiSelectHost), .devDataOe(link.devDataOe));
    // user-side register file, one cycle read latency
    always_ff @(posedge core_clk)
    begin
        if (regWr)
            mem[regAddr] <= regWrData;
        regRdData <= mem[regAddr];
    end
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmpCount++;
        if (seen !== exp)
        begin
            errTotal++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic settle();
        repeat (8) @(posedge core_clk);
        #1;
    endtask
    // one command cycle; read data taken in the next cycle
    task automatic cmd(input logic [3:0] a, input logic [15:0] d, input logic w);
        @(posedge core_clk);
        cmdAddr <= a;
        cmdWrData <= d;
        cmdWr <= w;
        cmdRd <= !w;
        @(posedge core_clk);
        cmdWr <= 1'b0;
        cmdRd <= 1'b0;
        #1 rv = cmdRdData;
    endtask
    task automatic acc(input logic [12:0] a, input logic [7:0] d, input logic rd);
        int n;
        cmd(REG_ADDR, 16'(a), 1'b1);
        cmd(REG_WDATA, 16'(d), 1'b1);
        cmd(REG_CMD, 16'(rd), 1'b1);
        rv = 16'h0000;
        for (n = 0; n < 400 && rv[1] !== 1'b1; n++)
            cmd(REG_STATUS, 16'h0000, 1'b0);
        if (rv[1] !== 1'b1)
        begin
            errTotal++;
            giveVerdict();
        end
        if (rd)
        begin
            cmd(REG_RDATA, 16'h0000, 1'b0);
            chk(rv & 16'h00FF, 16'(d));
        end
    endtask
    task automatic xfer(input logic [12:0] a, input logic [7:0] d);
        acc(a, d, 1'b0);
        acc(a, d, 1'b1);
        chk(16'(mem[a]), 16'(d));
    endtask
    task automatic giveVerdict();
        $display("comparisons %0d mismatches %0d", cmpCount, errTotal);
        if (errTotal == 0 && cmpCount > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        settle();
        chk(16'(spiMode), 16'h0000);
        xfer(13'h1FFF, 8'hA5);
        cmd(REG_CTRL, 16'h0002, 1'b1);
        xfer(13'h0AAA, 8'h3C);
        cmd(REG_CTRL, 16'h0000, 1'b1);
        chk(16'(link.statusLine), 16'h0000);
        for (k = 0; k < 4; k++)
        begin
            @(posedge core_clk);
            statusPinMode <= 1'b1;
            statusSelect <= 2'(k);
            settle();
            chk(16'(link.statusLine), 16'(k < 3 && stat[k % 3]));
        end
        // each unit level: masked, enabled, globally masked, serviced
        for (k = 0; k < 3; k++)
        begin
            @(posedge core_clk);
            statusPinMode <= 1'b0;
            globalIrqEnable <= 1'b1;
            irq[k] <= 8'h80;
            settle();
            chk(16'(link.interruptLine), 16'h0001);
            @(posedge core_clk);
            irqEn[k] <= 8'h80;
            settle();
            chk(16'(link.interruptLine), 16'h0000);
            cmd(REG_STATUS, 16'h0000, 1'b0);
            chk(16'(rv[2]), 16'h0001);
            @(posedge core_clk);
            globalIrqEnable <= 1'b0;
            settle();
            chk(16'(link.interruptLine), 16'h0001);
            @(posedge core_clk);
            globalIrqEnable <= 1'b1;
            irq[k] <= 8'h00;
            settle();
            chk(16'(link.interruptLine), 16'h0001);
        end
        // serial: strap needs a device reset; sweep swap, polarity and phase
        for (k = 0; k < 8; k++)
        begin
            cmd(REG_CTRL, 16'({k[0], k[2], k[1], 2'b01}), 1'b1);
            @(posedge core_clk);
            devRun <= 1'b0;
            repeat (2) @(posedge core_clk);
            devRun <= 1'b1;
            settle();
            chk(16'(spiMode), 16'h0001);
            xfer(13'h1234 ^ 13'(k), 8'h96 ^ 8'(k));
        end
        giveVerdict();
    end
endmodule
`default_nettype wire
